// ---- hdl/cam_pkg.sv ----
package cam_pkg;

    // ********************
    // address map of the two 64 KB spaces
    // ********************
    localparam logic [15:0] RAM_LO          = 16'h0040; // ram window low
    localparam logic [15:0] RAM_HI          = 16'h083F; // ram window high
    localparam logic [15:0] BOOT_LO         = 16'h1000; // boot rom low
    localparam logic [15:0] BOOT_HI         = 16'h17FF; // first 2 KB end
    localparam logic [15:0] FLASH_LO        = 16'h8000; // flash base
    localparam logic [15:0] SFR1_HI         = 16'h003F; // first sfr block
    localparam logic [15:0] SFR3_LO         = 16'h0E40; // third sfr block
    localparam logic [15:0] SFR2_HI         = 16'h0FFF; // second sfr end
    localparam logic [15:0] VCALL_LO        = 16'hFFA0; // vector calls
    localparam logic [15:0] VCALL_HI        = 16'hFFBF;
    localparam logic [15:0] VINT_LO         = 16'hFFCC; // interrupt vectors
    localparam logic [15:0] VINT_HI         = 16'hFFFD; // below reset vec
    localparam logic [15:0] VEC_RAM_OFFSET  = 16'hFE00; // 0xFFA0 -> 0x01A0

    // ********************
    // device registers on the data space
    // ********************
    localparam logic [15:0] FLASH_CTRL_ADDR = 16'h0FD0; // flash_map_control
    localparam logic [15:0] FLASH_KEY_ADDR  = 16'h0FD1; // flash_commit_key
    localparam logic [15:0] RST_STAT_ADDR   = 16'h0FDB; // fault clear stage
    localparam logic [15:0] STAGE_ADDR      = 16'h0FDE; // staging control
    localparam logic [15:0] KEY_ADDR        = 16'h0FDF; // key w, status r
    localparam logic [7:0]  FLASH_CTRL_RST  = 8'h40;
    localparam logic [7:0]  STAGE_RST       = 8'h00;
    localparam int          BIT_RSTDIS      = 0;
    localparam int          BIT_RAMMAP      = 1;
    localparam int          BIT_VECREL      = 2;
    localparam int          BIT_BOOTMAP     = 4;
    localparam int          BIT_FCLR        = 0;
    localparam logic [7:0]  KEY_MAP         = 8'hD4;
    localparam logic [7:0]  KEY_RSTDIS      = 8'hB2;
    localparam logic [7:0]  KEY_FCLR        = 8'h71;
    localparam logic [7:0]  KEY_FLASH       = 8'hD5;
    localparam logic [7:0]  SWI_OPCODE      = 8'hFF; // software interrupt
    localparam logic [7:0]  OPEN_BUS        = 8'hFF; // unmapped data read

    // ********************
    // who answers an access
    // ********************
    typedef enum logic [2:0] {
        TGT_NONE  = 3'b000,
        TGT_RAM   = 3'b001,
        TGT_BOOT  = 3'b010,
        TGT_FLASH = 3'b011,
        TGT_SFR   = 3'b100,
        TGT_SWI   = 3'b101
    } cam_target_type;

    // ********************
    // host register map (axi4-lite, byte addresses)
    // ********************
    localparam logic [3:0]  HREG_REQ        = 4'h0;
    localparam logic [3:0]  HREG_STATUS     = 4'h4;
    localparam logic [3:0]  HREG_MAPADDR    = 4'h8;
    localparam int          HB_WDATA        = 16;
    localparam int          HB_WRITE        = 24;
    localparam int          HB_FETCH        = 25;
    localparam int          HB_DONE         = 1;
    localparam int          HB_RDATA        = 8;
    localparam int          HB_TARGET       = 16;
    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;

endpackage

// ---- hdl/cam_if.sv ----
interface cam_if;
    logic                  req;       // one-cycle access strobe
    logic                  isFetch;   // 1 code space, 0 data space
    logic                  isWrite;   // data write
    logic [15:0]           addr;      // cpu address
    logic [7:0]            wdata;     // write data
    logic                  ack;       // one-cycle answer
    logic [7:0]            rdata;     // register, opcode or open bus
    logic [15:0]           mappedAddr;// address inside the target
    cam_pkg::cam_target_type target;  // who answers

    modport dev (input req, isFetch, isWrite, addr, wdata,
                 output ack, rdata, mappedAddr, target);
    modport cpu (output req, isFetch, isWrite, addr, wdata,
                 input ack, rdata, mappedAddr, target);
endinterface

// ---- hdl/cam_map_device.sv ----
// Functional notes
// R1: code and data decoded as separate spaces
// R2: ram not in code space after reset
// R3: committed ram bit maps code ram window
// R4: vector calls move to ram on relocation
// R5: interrupt vectors move to ram on relocation
// R6: reset vector never relocated
// R7: serial mode always maps code ram
// R8: unmapped code ram fetch returns swi
// R9: staged bits act only after key
// R10: software sets both bits for ram vectors
// R11: ram loader keeps relocation bit set
// R12: staging upper bits zero, reset zero
// R13: key b2 commits reset disable
// R14: key 71 commits fault flag clear
// R15: other key values do nothing
// R16: key register is write only
// R17: status shows committed ram and vector
// R18: status upper bits read zero
// R19: boot rom unmapped after reset
// R20: boot map committed by flash key
// R21: unmapped boot fetch gives flash or swi
// R22: only first 2 KB boot outside serial
// R23: boot map bit double buffered
// R24: commit on write edge, next access
//
// The implementer's own choice: the AXI4-Lite slave port.
module cam_map_device #(
    parameter logic [15:0] FlashBase    = cam_pkg::FLASH_LO, // flash size
    parameter logic [15:0] BootSerialHi = 16'h1FFF  // boot end in serial
) (
    input  wire logic  core_clk,
    input  wire logic  srst,
    cam_if.dev         bus,
    input  wire logic  serialModePin,
    output logic       bootRomMapped,
    output logic       resetDisable,
    output logic       faultClearPulse
);

    // ********************
    // shared decode helper
    // ********************

    // inclusive window test, used by both space decoders
    function automatic logic inRange(input logic [15:0] a,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
        inRange = (a >= lo) && (a <= hi);
    endfunction

    // ********************
    // state
    // ********************
    logic [2:0] stage_reg;      // staged rstdis, ram map, vector rel
    logic       ramMap_reg;     // committed ram-to-code mapping
    logic       vecRel_reg;     // committed vector relocation
    logic       rstDis_reg;     // committed reset disable
    logic       fclrStage_reg;  // staged fault flag clear
    logic       fclrPulse_reg;  // one-cycle commit of fault clear
    logic [7:0] flashCtl_reg;   // flash map control, staged copy
    logic       bootMap_reg;    // active boot rom mapping copy
    logic       serialMeta_reg; // pin synchroniser, first stage
    logic       serial_reg;     // pin synchroniser, second stage
    logic       ack_reg;        // answer strobe
    logic [7:0] rdata_reg;      // answer data
    logic [15:0] mapped_reg;    // answer address
    cam_pkg::cam_target_type target_reg;

    // ********************
    // access qualifiers
    // ********************
    wire logic dataWr   = bus.req && !bus.isFetch && bus.isWrite;
    wire logic keyWr    = dataWr && (bus.addr == cam_pkg::KEY_ADDR);
    wire logic flashKey = dataWr && (bus.addr == cam_pkg::FLASH_KEY_ADDR);
    // unknown key values fall through every compare below
    wire logic keyMap   = keyWr && (bus.wdata == cam_pkg::KEY_MAP);    // R15
    wire logic keyRst   = keyWr && (bus.wdata == cam_pkg::KEY_RSTDIS); // R15
    wire logic keyFclr  = keyWr && (bus.wdata == cam_pkg::KEY_FCLR);   // R15
    wire logic keyBoot  = flashKey && (bus.wdata == cam_pkg::KEY_FLASH);

    // ********************
    // code space decode
    // ********************
    wire logic [15:0] a = bus.addr;
    // serial mode overrides the committed ram bit for the loader
    wire logic ramInCode  = ramMap_reg || serial_reg;              // R7
    wire logic [15:0] bootHi = serial_reg ? BootSerialHi
                                          : cam_pkg::BOOT_HI;       // R22
    // the reset vector sits above VINT_HI so it is never caught
    wire logic vecHit  = vecRel_reg
                      && (inRange(a, cam_pkg::VCALL_LO, cam_pkg::VCALL_HI)
                       || inRange(a, cam_pkg::VINT_LO, cam_pkg::VINT_HI));
    wire logic codeRam  = inRange(a, cam_pkg::RAM_LO, cam_pkg::RAM_HI);
    wire logic bootWin  = inRange(a, cam_pkg::BOOT_LO, bootHi);
    wire logic flashHit = (a >= FlashBase);
    cam_pkg::cam_target_type codeTgt;
    logic [15:0]             codeAddr;

    // priority: relocated vectors, ram window, boot window, flash
    always_comb begin
        codeTgt  = cam_pkg::TGT_SWI;
        codeAddr = a;
        if (vecHit) begin                                            // R6
            codeTgt  = cam_pkg::TGT_RAM;                             // R4 R5
            codeAddr = a - cam_pkg::VEC_RAM_OFFSET;
        end else if (codeRam) begin
            // outside the mapping the fetch reads a trap opcode
            codeTgt = ramInCode ? cam_pkg::TGT_RAM
                                : cam_pkg::TGT_SWI;                  // R2 R3 R8
        end else if (bootWin && bootMap_reg) begin
            codeTgt = cam_pkg::TGT_BOOT;                             // R20
        end else if (flashHit) begin
            // small flash leaves the unmapped boot window as swi
            codeTgt = cam_pkg::TGT_FLASH;                            // R21
        end
    end

    // ********************
    // data space decode
    // ********************
    wire logic sfrHit = (a <= cam_pkg::SFR1_HI)
                     || inRange(a, cam_pkg::SFR3_LO, cam_pkg::SFR2_HI);
    cam_pkg::cam_target_type dataTgt;

    // data space ignores the ram map and vector relocation bits; only the boot map and the serial boot window end apply
    always_comb begin                                                // R1
        dataTgt = cam_pkg::TGT_NONE;
        if (sfrHit) begin
            dataTgt = cam_pkg::TGT_SFR;
        end else if (codeRam) begin
            dataTgt = cam_pkg::TGT_RAM;
        end else if (bootWin && bootMap_reg) begin
            dataTgt = cam_pkg::TGT_BOOT;                             // R19 R20
        end else if (flashHit) begin
            dataTgt = cam_pkg::TGT_FLASH;
        end
    end

    // ********************
    // register read mux
    // ********************
    logic [7:0] regRd;

    // key address reads the committed status, never the key
    always_comb begin
        regRd = cam_pkg::OPEN_BUS;
        unique case (a)
            cam_pkg::STAGE_ADDR:      regRd = {5'h00, stage_reg};     // R12
            cam_pkg::KEY_ADDR:        regRd = {5'h00, vecRel_reg,
                                               ramMap_reg,
                                               rstDis_reg};           // R16 R17 R18
            cam_pkg::FLASH_CTRL_ADDR: regRd = flashCtl_reg;
            cam_pkg::RST_STAT_ADDR:   regRd = {7'h00, fclrStage_reg};
            default: begin
                regRd = sfrHit ? 8'h00 : cam_pkg::OPEN_BUS;
            end
        endcase
    end

    wire logic [7:0] dataRd = (dataTgt == cam_pkg::TGT_SFR) ? regRd
                            : (dataTgt == cam_pkg::TGT_NONE)
                              ? cam_pkg::OPEN_BUS : 8'h00;
    wire logic [7:0] codeRd = (codeTgt == cam_pkg::TGT_SWI)
                              ? cam_pkg::SWI_OPCODE : 8'h00;

    // ********************
    // serial mode pin synchroniser
    // ********************

    // pin is asynchronous to core_clk, two stages before use
    always_ff @(posedge core_clk) begin
        if (srst) begin
            serialMeta_reg <= 1'b0;
            serial_reg     <= 1'b0;
        end else begin
            serialMeta_reg <= serialModePin;
            serial_reg     <= serialMeta_reg;
        end
    end

    // ********************
    // staging and commit registers
    // ********************

    // writes land in the staging copies only
    always_ff @(posedge core_clk) begin
        if (srst) begin
            stage_reg     <= cam_pkg::STAGE_RST[2:0]; // R12
            fclrStage_reg <= 1'b0;
            flashCtl_reg  <= cam_pkg::FLASH_CTRL_RST;
        end else if (dataWr) begin
            if (a == cam_pkg::STAGE_ADDR) begin
                stage_reg <= bus.wdata[2:0];                         // R9
            end
            if (a == cam_pkg::RST_STAT_ADDR) begin
                fclrStage_reg <= bus.wdata[cam_pkg::BIT_FCLR];
            end
            if (a == cam_pkg::FLASH_CTRL_ADDR) begin
                flashCtl_reg <= bus.wdata;                           // R23
            end
        end
    end

    // commits take effect at the edge that takes the key write,
    // so the very next access decodes with the new copies
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ramMap_reg    <= 1'b0;                                   // R2
            vecRel_reg    <= 1'b0;
            rstDis_reg    <= 1'b0;
            bootMap_reg   <= 1'b0;                                   // R19
            fclrPulse_reg <= 1'b0;
        end else begin
            if (keyMap) begin                                        // R24
                ramMap_reg <= stage_reg[cam_pkg::BIT_RAMMAP];        // R3 R9
                vecRel_reg <= stage_reg[cam_pkg::BIT_VECREL];        // R9
            end
            if (keyRst) begin
                rstDis_reg <= stage_reg[cam_pkg::BIT_RSTDIS];        // R13
            end
            if (keyBoot) begin
                bootMap_reg <= flashCtl_reg[cam_pkg::BIT_BOOTMAP];   // R23
            end
            fclrPulse_reg <= keyFclr && fclrStage_reg;               // R14
        end
    end

    // ********************
    // answer register
    // ********************

    // every request is answered exactly one cycle later
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ack_reg    <= 1'b0;
            rdata_reg  <= 8'h00;
            mapped_reg <= 16'h0000;
            target_reg <= cam_pkg::TGT_NONE;
        end else begin
            ack_reg <= bus.req;
            if (bus.req) begin
                target_reg <= bus.isFetch ? codeTgt : dataTgt;       // R1
                mapped_reg <= bus.isFetch ? codeAddr : a;
                rdata_reg  <= bus.isFetch ? codeRd : dataRd;
            end
        end
    end

    assign bus.ack         = ack_reg;
    assign bus.rdata       = rdata_reg;
    assign bus.mappedAddr  = mapped_reg;
    assign bus.target      = target_reg;
    assign bootRomMapped   = bootMap_reg;
    assign resetDisable    = rstDis_reg;
    assign faultClearPulse = fclrPulse_reg;

endmodule

// ---- hdl/cam_cpu_port.sv ----
module cam_cpu_port (
    input  wire logic        core_clk,
    input  wire logic        srst,
    cam_if.cpu               bus,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // ********************
    // state
    // ********************
    logic [25:0] reqCmd_reg;   // addr, wdata, write, fetch
    logic        busy_reg;     // access outstanding on the link
    logic        done_reg;     // last access answered
    logic        launch_reg;   // one-cycle request strobe
    logic [7:0]  rdata_reg;    // captured answer data
    logic [2:0]  target_reg;   // captured answer target
    logic [15:0] mapped_reg;   // captured mapped address
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [1:0]  rresp_reg;
    logic [31:0] rdataAxi_reg;

    // ********************
    // axi write channel decode
    // ********************
    // both channels taken together; simpler than buffering either
    wire logic wrTake = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
    wire logic wrReq  = wrTake && (s_axi_awaddr == cam_pkg::HREG_REQ);
    // a new order while one is outstanding is dropped (status busy)
    wire logic launch = wrReq && !busy_reg && (&s_axi_wstrb[3:0]);
    wire logic rdTake = s_axi_arvalid && !rvalid_reg;

    assign s_axi_awready = wrTake;
    assign s_axi_wready  = wrTake;
    assign s_axi_arready = rdTake;

    // write response: okay for the order register, error elsewhere
    always_ff @(posedge core_clk) begin
        if (srst) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= cam_pkg::RESP_OKAY;
        end else if (wrTake) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wrReq ? cam_pkg::RESP_OKAY : cam_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // ********************
    // link sequencing
    // ********************

    // hold the order, strobe the link, wait for the device answer
    always_ff @(posedge core_clk) begin
        if (srst) begin
            reqCmd_reg <= 26'h0000000;
            busy_reg   <= 1'b0;
            done_reg   <= 1'b0;
            launch_reg <= 1'b0;
            rdata_reg  <= 8'h00;
            target_reg <= 3'h0;
            mapped_reg <= 16'h0000;
        end else begin
            launch_reg <= launch;
            if (launch) begin
                reqCmd_reg <= s_axi_wdata[25:0];
                busy_reg   <= 1'b1;
                done_reg   <= 1'b0;
            end else if (busy_reg && bus.ack) begin
                busy_reg   <= 1'b0;
                done_reg   <= 1'b1;
                rdata_reg  <= bus.rdata;
                target_reg <= bus.target;
                mapped_reg <= bus.mappedAddr;
            end
        end
    end

    assign bus.req     = launch_reg;
    assign bus.addr    = reqCmd_reg[15:0];
    assign bus.wdata   = reqCmd_reg[23:16];
    assign bus.isWrite = reqCmd_reg[cam_pkg::HB_WRITE];
    assign bus.isFetch = reqCmd_reg[cam_pkg::HB_FETCH];

    // ********************
    // axi read channel
    // ********************
    wire logic [31:0] statusWord = {13'h0000, target_reg, rdata_reg,
                                    6'h00, done_reg, busy_reg};
    wire logic rdKnown = (s_axi_araddr == cam_pkg::HREG_REQ)
                      || (s_axi_araddr == cam_pkg::HREG_STATUS)
                      || (s_axi_araddr == cam_pkg::HREG_MAPADDR);

    // registered read data, held until rready
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rvalid_reg   <= 1'b0;
            rresp_reg    <= cam_pkg::RESP_OKAY;
            rdataAxi_reg <= 32'h00000000;
        end else if (rdTake) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= rdKnown ? cam_pkg::RESP_OKAY : cam_pkg::RESP_SLVERR;
            unique case (s_axi_araddr)
                cam_pkg::HREG_REQ:     rdataAxi_reg <= {6'h00, reqCmd_reg};
                cam_pkg::HREG_STATUS:  rdataAxi_reg <= statusWord;
                cam_pkg::HREG_MAPADDR: rdataAxi_reg <= {16'h0000, mapped_reg};
                default:               rdataAxi_reg <= 32'h00000000;
            endcase
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp  = rresp_reg;
    assign s_axi_rdata  = rdataAxi_reg;

endmodule

// ---- bench/cam_map_props.sv ----
// ****************************************
// link checker: decode against shadow bits
// ****************************************
module cam_map_props (
    input wire logic        core_clk,
    input wire logic        srst,
    input wire logic        req,
    input wire logic        isFetch,
    input wire logic        isWrite,
    input wire logic [15:0] addr,
    input wire logic [7:0]  wdata,
    input wire logic        ack,
    input wire logic [7:0]  rdata,
    input wire logic [15:0] mappedAddr,
    input wire logic [2:0]  target
);
    logic [1:0] stage_reg; // staged {vector, ram}
    logic [1:0] live_reg;  // committed {vector, ram}
    wire cf = req && isFetch;             // code fetch taken
    wire dw = req && !isFetch && isWrite; // data write taken
    wire tRam = target == cam_pkg::TGT_RAM;
    wire inRam = addr >= cam_pkg::RAM_LO && addr <= cam_pkg::RAM_HI;
    wire inVec = (addr >= cam_pkg::VCALL_LO && addr <= cam_pkg::VCALL_HI)
        || (addr >= cam_pkg::VINT_LO && addr <= cam_pkg::VINT_HI);
    wire keyHit = dw && addr == cam_pkg::KEY_ADDR;
    // shadow follows staging writes; only the map key commits
    always_ff @(posedge core_clk) begin
        if (srst) begin
            stage_reg <= 2'h0;
            live_reg <= 2'h0;
        end else if (dw && addr == cam_pkg::STAGE_ADDR) begin
            stage_reg <= wdata[2:1];
        end else if (keyHit && wdata == cam_pkg::KEY_MAP) begin
            live_reg <= stage_reg;
        end
    end
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (srst);
    a_ack_follows_req: assert property (
        req |=> ack) else $error("no ack after request");
    a_no_stray_ack: assert property (
        !req |=> !ack) else $error("ack without request");
    a_code_ram_swi: assert property (
        cf && inRam && !live_reg[0] |=> target == cam_pkg::TGT_SWI
        && rdata == cam_pkg::SWI_OPCODE) else $error("ram fetch not swi");
    a_code_ram_live: assert property (
        cf && inRam && live_reg[0] |=> tRam) else $error("ram not in code");
    a_data_ram_seen: assert property (
        req && !isFetch && inRam |=> tRam) else $error("data ram missed");
    a_vec_moved: assert property (
        cf && inVec && live_reg == 2'h3 |=> tRam && mappedAddr
        == $past(addr) - cam_pkg::VEC_RAM_OFFSET) else $error("vector map");
    a_reset_vec_fixed: assert property (
        cf && addr >= 16'hFFFE |=> target == cam_pkg::TGT_FLASH)
        else $error("reset vector moved");
    a_status_bits: assert property (
        req && !isFetch && !isWrite && addr == cam_pkg::KEY_ADDR
        |=> rdata[7:1] == {5'h00, live_reg}) else $error("status wrong");
    c_key_commit: cover property (keyHit && wdata == cam_pkg::KEY_MAP);
    c_vec_fetch: cover property (cf && inVec && live_reg == 2'h3);
    c_swi_fetch: cover property (cf && inRam && !live_reg[0]);
endmodule

// ---- bench/code_area_memory_remap_test.sv ----
module code_area_memory_remap_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, got;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, rstDis, bootOn, fclr;
    logic serial = 1'b0, fclrSeen = 1'b0;
    logic [1:0] bresp, rresp;
    int miscompares = 0, tests_run = 0, n;
    always #2.5 core_clk = ~core_clk;
    // latch the one-cycle fault clear pulse
    always @(posedge core_clk) if (fclr) fclrSeen <= 1'b1;
    cam_if bus ();
    cam_map_device u_cam_map_device (.core_clk, .srst, .bus(bus.dev),
        .serialModePin(serial), .bootRomMapped(bootOn),
        .resetDisable(rstDis), .faultClearPulse(fclr));
    cam_cpu_port u_cam_cpu_port (.core_clk, .srst, .bus(bus.cpu),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    cam_map_props u_cam_map_props (.core_clk, .srst, .req(bus.req),
        .isFetch(bus.isFetch), .isWrite(bus.isWrite), .addr(bus.addr),
        .wdata(bus.wdata), .ack(bus.ack), .rdata(bus.rdata),
        .mappedAddr(bus.mappedAddr), .target(bus.target));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // one edge of a bounded wait; a hang ends the run
    task automatic tick();
        @(posedge core_clk);
        n++;
        if (n > 200) begin
            miscompares++;
            report_and_stop();
        end
    endtask
    task automatic chkd(input string s, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", s, e, g);
        end
    endtask
    // address and data offered together, response in got
    task automatic axw(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do tick(); while (!(awready && wready));
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do tick(); while (!bvalid);
        got = {30'h0, bresp};
        bready <= 1'b0;
    endtask
    task automatic axr(input logic [3:0] a);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do tick(); while (!arready);
        arvalid <= 1'b0;
        do tick(); while (!rvalid);
        got = rdata;
        rready <= 1'b0;
    endtask
    // one link access, then poll status until done
    task automatic acc(input logic f, w, input logic [15:0] a,
                       input logic [7:0] d);
        int m;
        axw(4'h0, {6'h00, f, w, d, a});
        m = 0;
        do begin
            axr(4'h4);
            m++;
        end while (got[1:0] !== 2'b10 && m < 20);
        chkd("done", 32'h2, {30'h0, got[1:0]});
    endtask
    task automatic ex(input logic f, input logic [15:0] a,
                      input logic [2:0] t, input logic [7:0] d);
        acc(f, 1'b0, a, 8'h00);
        chkd("target", {29'h0, t}, {29'h0, got[18:16]});
        chkd("rdata", {24'h0, d}, {24'h0, got[15:8]});
    endtask
    initial begin
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        ex(1'b0, 16'h0FDF, cam_pkg::TGT_SFR, 8'h00);
        ex(1'b1, 16'h0040, cam_pkg::TGT_SWI, 8'hFF);
        ex(1'b1, 16'h083F, cam_pkg::TGT_SWI, 8'hFF);
        ex(1'b0, 16'h0040, cam_pkg::TGT_RAM, 8'h00);
        ex(1'b1, 16'h1000, cam_pkg::TGT_SWI, 8'hFF);
        ex(1'b0, 16'h17FF, cam_pkg::TGT_NONE, 8'hFF);
        acc(1'b0, 1'b1, 16'h0FDE, 8'hFF);
        ex(1'b0, 16'h0FDE, cam_pkg::TGT_SFR, 8'h07);
        ex(1'b1, 16'h0040, cam_pkg::TGT_SWI, 8'hFF);
        acc(1'b0, 1'b1, 16'h0FDF, 8'h55);
        ex(1'b0, 16'h0FDF, cam_pkg::TGT_SFR, 8'h00);
        acc(1'b0, 1'b1, 16'h0FDF, 8'hB2);
        chkd("rstdis", 32'h1, {31'h0, rstDis});
        acc(1'b0, 1'b1, 16'h0FDF, 8'hD4);
        ex(1'b0, 16'h0FDF, cam_pkg::TGT_SFR, 8'h07);
        ex(1'b1, 16'h0040, cam_pkg::TGT_RAM, 8'h00);
        ex(1'b1, 16'hFFA0, cam_pkg::TGT_RAM, 8'h00);
        axr(4'h8);
        chkd("mapped", 32'h01A0, {16'h0, got[15:0]});
        ex(1'b1, 16'hFFFD, cam_pkg::TGT_RAM, 8'h00);
        ex(1'b1, 16'hFFFE, cam_pkg::TGT_FLASH, 8'h00);
        acc(1'b0, 1'b1, 16'h0FD0, 8'h50);
        ex(1'b1, 16'h1000, cam_pkg::TGT_SWI, 8'hFF);
        acc(1'b0, 1'b1, 16'h0FD1, 8'hD5);
        chkd("boot", 32'h1, {31'h0, bootOn});
        ex(1'b0, 16'h17FF, cam_pkg::TGT_BOOT, 8'h00);
        ex(1'b1, 16'h1800, cam_pkg::TGT_SWI, 8'hFF);
        acc(1'b0, 1'b1, 16'h0FDB, 8'h01);
        acc(1'b0, 1'b1, 16'h0FDF, 8'h71);
        chkd("fclr", 32'h1, {31'h0, fclrSeen});
        serial <= 1'b1;
        ex(1'b1, 16'h1800, cam_pkg::TGT_BOOT, 8'h00);
        axw(4'hC, 32'h0);
        chkd("bresp", {30'h0, cam_pkg::RESP_SLVERR}, got);
        report_and_stop();
    end
endmodule
